// ==== hdl/capture_compare_unit_pkg.sv ====
package capture_compare_unit_pkg;
	localparam int NCH         = 32;
	localparam int CH_PER_UNIT = 16;
	localparam int NTMR        = 4;
	localparam int TW          = 16;
	localparam int DBL_OFS     = 8;

	// register byte offsets
	localparam logic [11:0] OFS_TCTL = 12'h000;
	localparam logic [11:0] OFS_TVAL = 12'h010;
	localparam logic [11:0] OFS_TREL = 12'h020;
	localparam logic [11:0] OFS_CCFG = 12'h100;
	localparam logic [11:0] OFS_CVAL = 12'h200;
	localparam logic [11:0] OFS_CHST = 12'h300;
	localparam logic [11:0] OFS_CHEN = 12'h304;
	localparam logic [11:0] OFS_TST  = 12'h308;
	localparam logic [11:0] OFS_TMSK = 12'h30C;

	// timer control fields
	localparam int TCTL_W    = 6;
	localparam int TCTL_SEL  = 0;
	localparam int TCTL_AUX  = 3;
	localparam int TCTL_EXT  = 4;
	localparam int TCTL_RUN  = 5;

	// channel config fields
	localparam int CCFG_W    = 7;
	localparam int CCFG_MODE = 0;
	localparam int CCFG_TSEL = 3;
	localparam int CCFG_EDGE = 4;
	localparam int CCFG_DBL  = 6;

	localparam logic [TW-1:0] TMR_MAX   = 16'hFFFF;
	localparam logic [TW-1:0] TMR_RST   = 16'h0000;
	localparam logic [9:0]    PSC_BASE  = 10'h008;
	localparam logic [9:0]    PSC_ONE   = 10'h001;

	typedef enum logic [2:0] {
		CM_OFF  = 3'h0,
		CM_CAP  = 3'h1,
		CM_CMP0 = 3'h4,
		CM_CMP1 = 3'h5,
		CM_CMP2 = 3'h6,
		CM_CMP3 = 3'h7
	} ch_mode_e;

	typedef enum logic [3:0] {
		RG_NONE, RG_TCTL, RG_TVAL, RG_TREL, RG_CCFG,
		RG_CVAL, RG_CHST, RG_CHEN, RG_TST, RG_TMSK
	} region_e;
endpackage

// ==== hdl/dual_capture_compare_array.sv ====
module dual_capture_compare_array (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	// apb slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// channel pins
	input  wire logic [31:0] CC_PIN_I,
	output logic      [31:0] CC_PIN_O,
	output logic      [31:0] CC_PIN_OE_O,
	// count sources
	input  wire logic [1:0]  EXT_COUNT_I,
	input  wire logic        AUX_OVF_I,
	// interrupts
	output logic      [31:0] CH_IRQ_O,
	output logic             IRQ_O
);
	localparam int NCH = capture_compare_unit_pkg::NCH;
	localparam int NT  = capture_compare_unit_pkg::NTMR;
	localparam int TW  = capture_compare_unit_pkg::TW;

	function automatic capture_compare_unit_pkg::region_e decode(input logic [11:0] a);
		if (a[1:0] != 2'h0)
			return capture_compare_unit_pkg::RG_NONE;
		else if (a[11:4] == capture_compare_unit_pkg::OFS_TCTL[11:4])
			return capture_compare_unit_pkg::RG_TCTL;
		else if (a[11:4] == capture_compare_unit_pkg::OFS_TVAL[11:4])
			return capture_compare_unit_pkg::RG_TVAL;
		else if (a[11:4] == capture_compare_unit_pkg::OFS_TREL[11:4])
			return capture_compare_unit_pkg::RG_TREL;
		else if (a[11:7] == capture_compare_unit_pkg::OFS_CCFG[11:7])
			return capture_compare_unit_pkg::RG_CCFG;
		else if (a[11:7] == capture_compare_unit_pkg::OFS_CVAL[11:7])
			return capture_compare_unit_pkg::RG_CVAL;
		else if (a == capture_compare_unit_pkg::OFS_CHST)
			return capture_compare_unit_pkg::RG_CHST;
		else if (a == capture_compare_unit_pkg::OFS_CHEN)
			return capture_compare_unit_pkg::RG_CHEN;
		else if (a == capture_compare_unit_pkg::OFS_TST)
			return capture_compare_unit_pkg::RG_TST;
		else if (a == capture_compare_unit_pkg::OFS_TMSK)
			return capture_compare_unit_pkg::RG_TMSK;
		else
			return capture_compare_unit_pkg::RG_NONE;
	endfunction

	// one tick every (8 << sel) cycles from the shared free-running divider
	function automatic logic psc_tick(input logic [9:0] cnt, input logic [2:0] sel);
		logic [9:0] m;
		m = (capture_compare_unit_pkg::PSC_BASE << sel) - capture_compare_unit_pkg::PSC_ONE;
		return (cnt & m) == m;
	endfunction

	capture_compare_unit_pkg::region_e rg;
	logic                wr;
	logic                setup;
	logic [31:0]         rd_nxt;
	logic                err_nxt;
	logic [31:0]         prdata_r;
	logic                pslverr_r;

	logic [9:0]          psc_r;
	logic [1:0]          ext_s1_r;
	logic [1:0]          ext_s2_r;
	logic [1:0]          ext_s3_r;
	logic [1:0]          ext_rise;
	logic [NCH-1:0]      pin_s1_r;
	logic [NCH-1:0]      pin_s2_r;
	logic [NCH-1:0]      pin_s3_r;

	logic [capture_compare_unit_pkg::TCTL_W-1:0] tctl_r [NT];
	logic [TW-1:0]       tval_r [NT];
	logic [TW-1:0]       trel_r [NT];
	logic [NT-1:0]       tick;
	logic [NT-1:0]       tovf;
	logic [NT-1:0]       tupd_r;
	logic [NT-1:0]       tst_r;
	logic [NT-1:0]       tmsk_r;

	logic [capture_compare_unit_pkg::CCFG_W-1:0] ccfg_r [NCH];
	logic [TW-1:0]       ccval_r [NCH];
	logic [NCH-1:0]      cmp_ev;
	logic [NCH-1:0]      ev;
	logic [NCH-1:0]      chst_r;
	logic [NCH-1:0]      chen_r;
	logic [NCH-1:0]      pin_r;
	logic [NCH-1:0]      oe;

	assign rg    = decode(PADDR_I);
	assign wr    = PSEL_I & PENABLE_I & PWRITE_I;
	assign setup = PSEL_I & ~PENABLE_I;

	// read data is sampled at the setup edge so the access phase needs no wait state
	always_comb begin
		rd_nxt  = 32'h0000_0000;
		err_nxt = 1'b0;
		case (rg)
			capture_compare_unit_pkg::RG_TCTL: rd_nxt[capture_compare_unit_pkg::TCTL_W-1:0] = tctl_r[PADDR_I[3:2]];
			capture_compare_unit_pkg::RG_TVAL: rd_nxt[TW-1:0] = tval_r[PADDR_I[3:2]];
			capture_compare_unit_pkg::RG_TREL: rd_nxt[TW-1:0] = trel_r[PADDR_I[3:2]];
			capture_compare_unit_pkg::RG_CCFG: rd_nxt[capture_compare_unit_pkg::CCFG_W-1:0] = ccfg_r[PADDR_I[6:2]];
			capture_compare_unit_pkg::RG_CVAL: rd_nxt[TW-1:0] = ccval_r[PADDR_I[6:2]];
			capture_compare_unit_pkg::RG_CHST: rd_nxt = chst_r;
			capture_compare_unit_pkg::RG_CHEN: rd_nxt = chen_r;
			capture_compare_unit_pkg::RG_TST:  rd_nxt[NT-1:0] = tst_r;
			capture_compare_unit_pkg::RG_TMSK: rd_nxt[NT-1:0] = tmsk_r;
			default:             err_nxt = 1'b1;
		endcase
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r  <= PWRITE_I ? 32'h0000_0000 : rd_nxt;
			pslverr_r <= err_nxt;
		end
	end

	assign PRDATA_O  = prdata_r;
	assign PSLVERR_O = pslverr_r;
	assign PREADY_O  = 1'b1;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			psc_r <= 10'h000;
		else
			psc_r <= psc_r + capture_compare_unit_pkg::PSC_ONE;
	end

	// pins and count inputs are asynchronous: two flops, then a third for edges
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ext_s1_r <= 2'h0;
			ext_s2_r <= 2'h0;
			ext_s3_r <= 2'h0;
			pin_s1_r <= 32'h0000_0000;
			pin_s2_r <= 32'h0000_0000;
			pin_s3_r <= 32'h0000_0000;
		end else begin
			ext_s1_r <= EXT_COUNT_I;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			pin_s1_r <= CC_PIN_I;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	assign ext_rise = ext_s2_r & ~ext_s3_r;

	genvar t;
	generate
		for (t = 0; t < NT; t++) begin : g_tmr
			logic wr_val;
			logic src;
			logic [2:0] sel;
			assign wr_val = wr && rg == capture_compare_unit_pkg::RG_TVAL && PADDR_I[3:2] == 2'(t);
			assign sel = tctl_r[t][capture_compare_unit_pkg::TCTL_SEL +: 3];
			// aux overflow, then external count (primary only), else prescaler
			always_comb begin
				if (tctl_r[t][capture_compare_unit_pkg::TCTL_AUX])
					src = AUX_OVF_I;
				else if ((t % 2 == 0) && tctl_r[t][capture_compare_unit_pkg::TCTL_EXT])
					src = ext_rise[t/2];
				else
					src = psc_tick(psc_r, sel);
			end
			assign tick[t] = tctl_r[t][capture_compare_unit_pkg::TCTL_RUN] & src;
			assign tovf[t] = tick[t] & ~wr_val & (tval_r[t] == capture_compare_unit_pkg::TMR_MAX);

			always_ff @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					tctl_r[t] <= '0;
					trel_r[t] <= capture_compare_unit_pkg::TMR_RST;
				end else if (wr && PADDR_I[3:2] == 2'(t)) begin
					if (rg == capture_compare_unit_pkg::RG_TCTL)
						tctl_r[t] <= PWDATA_I[capture_compare_unit_pkg::TCTL_W-1:0];
					else if (rg == capture_compare_unit_pkg::RG_TREL)
						trel_r[t] <= PWDATA_I[TW-1:0];
				end
			end

			// a software write beats a tick in the same cycle
			always_ff @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I)
					tval_r[t] <= capture_compare_unit_pkg::TMR_RST;
				else if (wr_val)
					tval_r[t] <= PWDATA_I[TW-1:0];
				else if (tovf[t])
					tval_r[t] <= trel_r[t];
				else if (tick[t])
					tval_r[t] <= tval_r[t] + 16'h0001;
			end

			// marks the cycle a new timer value is first visible, so a match fires once
			always_ff @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I)
					tupd_r[t] <= 1'b0;
				else
					tupd_r[t] <= tick[t] | wr_val;
			end
		end
	endgenerate

	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			localparam int U = c / capture_compare_unit_pkg::CH_PER_UNIT;
			capture_compare_unit_pkg::ch_mode_e mode;
			logic [1:0]    ti;
			logic [1:0]    edg;
			logic          rise;
			logic          fall;
			logic          cap_ev;
			logic          hit;
			logic          once;
			logic          fired_r;
			logic          partner;
			assign mode = capture_compare_unit_pkg::ch_mode_e'(ccfg_r[c][capture_compare_unit_pkg::CCFG_MODE +: 3]);
			assign ti   = {U[0], ccfg_r[c][capture_compare_unit_pkg::CCFG_TSEL]};
			assign edg  = ccfg_r[c][capture_compare_unit_pkg::CCFG_EDGE +: 2];
			assign rise = pin_s2_r[c] & ~pin_s3_r[c];
			assign fall = ~pin_s2_r[c] & pin_s3_r[c];
			assign cap_ev = (mode == capture_compare_unit_pkg::CM_CAP) &
				((edg[0] & rise) | (edg[1] & fall));
			assign hit  = mode[2] & tupd_r[ti] & (ccval_r[c] == tval_r[ti]);
			assign once = (mode == capture_compare_unit_pkg::CM_CMP2) | (mode == capture_compare_unit_pkg::CM_CMP3);
			assign cmp_ev[c] = hit & ~(once & fired_r);
			assign ev[c] = cap_ev | cmp_ev[c];
			assign oe[c] = (mode == capture_compare_unit_pkg::CM_CMP1) | (mode == capture_compare_unit_pkg::CM_CMP3);

			if ((c % capture_compare_unit_pkg::CH_PER_UNIT) < capture_compare_unit_pkg::DBL_OFS) begin : g_dbl
				assign partner = ccfg_r[c][capture_compare_unit_pkg::CCFG_DBL] & cmp_ev[c + capture_compare_unit_pkg::DBL_OFS];
			end else begin : g_nodbl
				assign partner = 1'b0;
			end

			// once-per-period lock, freed by the assigned timer's overflow
			always_ff @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I)
					fired_r <= 1'b0;
				else if (tovf[ti])
					fired_r <= 1'b0;
				else if (cmp_ev[c] & once)
					fired_r <= 1'b1;
			end

			always_ff @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I)
					ccfg_r[c] <= '0;
				else if (wr && rg == capture_compare_unit_pkg::RG_CCFG && PADDR_I[6:2] == 5'(c))
					ccfg_r[c] <= PWDATA_I[capture_compare_unit_pkg::CCFG_W-1:0];
			end

			// a capture beats a software write in the same cycle
			always_ff @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I)
					ccval_r[c] <= capture_compare_unit_pkg::TMR_RST;
				else if (cap_ev)
					ccval_r[c] <= tval_r[ti];
				else if (wr && rg == capture_compare_unit_pkg::RG_CVAL && PADDR_I[6:2] == 5'(c))
					ccval_r[c] <= PWDATA_I[TW-1:0];
			end

			// pin level is kept across mode changes; only the enable follows the mode
			always_ff @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I)
					pin_r[c] <= 1'b0;
				else if (mode == capture_compare_unit_pkg::CM_CMP1 && (cmp_ev[c] || partner))
					pin_r[c] <= ~pin_r[c];
				else if (mode == capture_compare_unit_pkg::CM_CMP3 && cmp_ev[c])
					pin_r[c] <= 1'b1;
				else if (mode == capture_compare_unit_pkg::CM_CMP3 && tovf[ti])
					pin_r[c] <= 1'b0;
			end
		end
	endgenerate

	assign CC_PIN_O    = pin_r;
	assign CC_PIN_OE_O = oe;

	// sticky flags: a new event wins over a write-one-to-clear
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			chst_r <= 32'h0000_0000;
			tst_r  <= 4'h0;
		end else begin
			chst_r <= (chst_r & ~((wr && rg == capture_compare_unit_pkg::RG_CHST) ? PWDATA_I : 32'h0000_0000))
				| ev;
			tst_r  <= (tst_r & ~((wr && rg == capture_compare_unit_pkg::RG_TST) ? PWDATA_I[NT-1:0] : 4'h0))
				| tovf;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			chen_r <= 32'h0000_0000;
			tmsk_r <= 4'h0;
		end else if (wr && rg == capture_compare_unit_pkg::RG_CHEN) begin
			chen_r <= PWDATA_I;
		end else if (wr && rg == capture_compare_unit_pkg::RG_TMSK) begin
			tmsk_r <= PWDATA_I[NT-1:0];
		end
	end

	assign CH_IRQ_O = chst_r & chen_r;
	assign IRQ_O    = (|(chst_r & chen_r)) | (|(tst_r & tmsk_r));
endmodule

// ==== sim/capture_compare_unit_checker.sv ====
module capture_compare_unit_checker (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	// apb
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PRDATA_O,
	input  wire logic        PREADY_O,
	input  wire logic        PSLVERR_O,
	// pins and interrupts
	input  wire logic [31:0] CC_PIN_O,
	input  wire logic [31:0] CC_PIN_OE_O,
	input  wire logic [31:0] CH_IRQ_O,
	input  wire logic        IRQ_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	logic wr;
	logic setup;
	assign wr = PSEL_I && PENABLE_I && PWRITE_I;
	assign setup = PSEL_I && !PENABLE_I;
	a_ready_const: assert property (PREADY_O) else $error("ready low");
	a_bad_addr: assert property (setup && PADDR_I[1:0] != 2'h0 |=> PSLVERR_O && PRDATA_O == 32'h0)
		else $error("misaligned access accepted");
	a_chen_mapped: assert property (setup && PADDR_I == capture_compare_unit_pkg::OFS_CHEN |=> !PSLVERR_O)
		else $error("mapped access refused");
	a_rdata_holds: assert property (PSEL_I && PENABLE_I |=> $stable(PRDATA_O))
		else $error("read data moved after access");
	// drive enable only follows configuration writes
	a_oe_by_write: assert property ($changed(CC_PIN_OE_O) |-> $past(wr))
		else $error("pin enable changed without write");
	a_pin_driven: assert property (((CC_PIN_O ^ $past(CC_PIN_O)) & ~$past(CC_PIN_OE_O)) == 32'h0)
		else $error("undriven pin moved");
	a_flag_sticky: assert property ((($past(CH_IRQ_O) & ~CH_IRQ_O) != 32'h0) |-> $past(wr))
		else $error("channel request dropped by itself");
	a_irq_any: assert property (CH_IRQ_O != 32'h0 |-> IRQ_O)
		else $error("summary request missing");
endmodule
bind dual_capture_compare_array capture_compare_unit_checker chk_i (
	.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O), .CC_PIN_O(CC_PIN_O), .CC_PIN_OE_O(CC_PIN_OE_O),
	.CH_IRQ_O(CH_IRQ_O), .IRQ_O(IRQ_O)
);

// ==== sim/pin_model.sv ====
module pin_model (
	// device side
	input  wire logic [31:0] oe,
	input  wire logic [31:0] drv,
	// external event levels
	input  wire logic [31:0] req,
	// resolved pin
	output logic      [31:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// a driven pin reads back its own level, else the event source
	assign pin = (oe & drv) | (~oe & req);
endmodule

// ==== sim/dual_capture_compare_array_tb.sv ====
module dual_capture_compare_array_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] TC = capture_compare_unit_pkg::OFS_TCTL;
	localparam logic [11:0] TV = capture_compare_unit_pkg::OFS_TVAL;
	localparam logic [11:0] TR = capture_compare_unit_pkg::OFS_TREL;
	localparam logic [11:0] CF = capture_compare_unit_pkg::OFS_CCFG;
	localparam logic [11:0] CV = capture_compare_unit_pkg::OFS_CVAL;
	localparam logic [11:0] ST = capture_compare_unit_pkg::OFS_CHST;
	localparam logic [11:0] EN = capture_compare_unit_pkg::OFS_CHEN;
	localparam logic [11:0] TS = capture_compare_unit_pkg::OFS_TST;
	localparam logic [11:0] TM = capture_compare_unit_pkg::OFS_TMSK;
	typedef struct packed {
		logic        w;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic        err;
	} row_s;
	row_s rows [5] = '{
		'{1'b0, EN, 32'h0, 32'h0, 1'b0},
		'{1'b1, TR + 12'h00C, 32'hA5A5, 32'hA5A5, 1'b0},
		'{1'b1, CF + 12'h024, 32'hFFFFFFFF, 32'h7F, 1'b0},
		'{1'b0, 12'hFFC, 32'h0, 32'h0, 1'b1},
		'{1'b1, 12'h102, 32'hFFFFFFFF, 32'h0, 1'b1}
	};
	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        pen;
	logic        pwr;
	logic [11:0] padr;
	logic [31:0] pwd;
	logic [31:0] prd;
	logic        rdy;
	logic        serr;
	logic [31:0] pin_in;
	logic [31:0] pin_out;
	logic [31:0] pin_oe;
	logic [31:0] pin_req;
	logic [1:0]  ext;
	logic        aux;
	logic [31:0] ch_irq;
	logic        irq;
	logic [31:0] r;
	logic        e;
	logic [15:0] v;
	int          n;
	int          err_count;
	int          cmp_count;
	dual_capture_compare_array uut (
		.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(serr),
		.CC_PIN_I(pin_in), .CC_PIN_O(pin_out), .CC_PIN_OE_O(pin_oe), .EXT_COUNT_I(ext),
		.AUX_OVF_I(aux), .CH_IRQ_O(ch_irq), .IRQ_O(irq)
	);
	pin_model pm (.oe(pin_oe), .drv(pin_out), .req(pin_req), .pin(pin_in));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rdy !== 1'b1 && k < 16);
		if (k == 16) begin
			err_count++;
			$display("BAD %0t ready never came", $time);
		end
		r = prd;
		e = serr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(negedge clk);
	endtask
	// counts cycles to the next level change of one pin
	task automatic wait_pin(input int b);
		logic p;
		p = pin_out[b];
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (pin_out[b] === p && n < 200);
	endtask
	task automatic give_verdict;
		if (err_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#1_000_000;
		err_count++;
		give_verdict;
	end
	initial begin
		{psel, pen, pwr, padr, pwd, pin_req, ext, aux} = '0;
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(pin_oe | pin_out | ch_irq, 32'h0);
		chk({30'h0, rdy, irq}, 32'h2);
		foreach (rows[i]) begin
			if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			chk(r, rows[i].x);
			chk({31'h0, e}, {31'h0, rows[i].err});
		end
		// reload FFFC gives a four-tick period, 32 cycles at prescale 8
		apb(1'b1, TR, 32'hFFFC);
		apb(1'b1, TV, 32'hFFFC);
		apb(1'b1, CV, 32'hFFFE);
		apb(1'b1, CV + 12'h004, 32'hFFFE);
		apb(1'b1, CF, 32'h5);
		apb(1'b1, CF + 12'h004, 32'h7);
		apb(1'b1, EN, 32'h1);
		apb(1'b1, TC, 32'h20);
		wait_pin(0);
		wait_pin(0);
		chk(32'(n), 32'd32);
		chk({31'h0, ch_irq[0] & irq}, 32'h1);
		wait_pin(1);
		if (pin_out[1] !== 1'b1) wait_pin(1);
		wait_pin(1);
		// set lags the tick by one cycle, overflow clears on the tick: high for 15 cycles
		chk({pin_out[1], 31'(n)}, {1'b0, 31'd15});
		// double mode: partner match at FFFE halves the toggle spacing to 16 cycles
		apb(1'b1, CV + 12'h018, 32'hFFFC);
		apb(1'b1, CV + 12'h038, 32'hFFFE);
		apb(1'b1, CF + 12'h038, 32'h4);
		apb(1'b1, CF + 12'h018, 32'h45);
		wait_pin(6);
		wait_pin(6);
		chk(32'(n), 32'd16);
		apb(1'b1, EN, 32'h0);
		apb(1'b0, ST, 32'h0);
		chk({31'h0, r[0] & ~ch_irq[0]}, 32'h1);
		apb(1'b1, TM, 32'h1);
		repeat (40) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, TM, 32'h0);
		apb(1'b1, ST, 32'hFFFFFFFF);
		apb(1'b1, TS, 32'hF);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, CV + 12'h008, 32'h10);
		apb(1'b1, CV + 12'h00C, 32'h10);
		apb(1'b1, CF + 12'h008, 32'hE);
		apb(1'b1, CF + 12'h00C, 32'hC);
		apb(1'b1, TC + 12'h004, 32'h20);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, TV + 12'h004, 32'hE);
			repeat (40) @(posedge clk);
			apb(1'b0, ST, 32'h0);
			chk(r & 32'hC, k ? 32'h8 : 32'hC);
			apb(1'b1, ST, 32'hC);
		end
		apb(1'b1, CF + 12'h010, 32'h19);
		apb(1'b1, CF + 12'h014, 32'h29);
		apb(1'b0, TV + 12'h004, 32'h0);
		v = r[15:0];
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			pin_req <= k ? 32'h0 : 32'h30;
			repeat (6) @(posedge clk);
			apb(1'b0, ST, 32'h0);
			chk(r & 32'h30, k ? 32'h30 : 32'h10);
		end
		apb(1'b0, CV + 12'h010, 32'h0);
		chk({31'h0, (r[15:0] - v) < 16'h3}, 32'h1);
		apb(1'b1, TC + 12'h008, 32'h30);
		apb(1'b1, TC + 12'h00C, 32'h28);
		apb(1'b0, TV + 12'h008, 32'h0);
		v = r[15:0];
		repeat (5) begin
			@(posedge clk);
			ext <= 2'h2;
			aux <= 1'b1;
			@(posedge clk);
			aux <= 1'b0;
			repeat (3) @(posedge clk);
			ext <= 2'h0;
			repeat (3) @(posedge clk);
		end
		repeat (4) @(posedge clk);
		apb(1'b0, TV + 12'h008, 32'h0);
		chk(32'(r[15:0] - v), 32'h5);
		apb(1'b0, TV + 12'h00C, 32'h0);
		chk(r, 32'h5);
		give_verdict;
	end
endmodule
